// ===== hw/pct_trim_regs.v
`include "pct_consts.vh"

module pct_trim_regs #(
	parameter MOD_DIV = `PCT_MOD_DIV,
	parameter DEPTH = `PCT_DELAY_DEPTH
) (
	input wire core_clk,
	input wire rst,
	input wire [7:0] reg_page,
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire pdm_bit_ch5,
	input wire pdm_bit_ch6,
	input wire sample_strobe,
	output reg mod_tick,
	output reg pdm_delayed_ch5,
	output reg pdm_delayed_ch6,
	output reg signed [4:0] ch5_gain_tenth_db,
	output reg signed [4:0] ch6_gain_tenth_db,
	output reg [7:0] ch5_phase_active,
	output reg signed [8:0] ch6_volume_half_db,
	output reg ch6_mute
);
	// ************************************************************
	// Register file
	// ************************************************************
	reg [3:0] ch5_gain_trim_code;
	reg [3:0] ch6_gain_trim_code;
	reg [7:0] ch5_phase_delay_code;
	reg [7:0] ch6_volume_code;
	wire page_hit;
	reg [7:0] next_rdata;

	assign page_hit = (reg_page == `PCT_PAGE_MAIN);

	always @(posedge core_clk) begin
		if (rst) begin
			ch5_gain_trim_code <= `PCT_GAIN_RST;
			ch6_gain_trim_code <= `PCT_GAIN_RST;
			ch5_phase_delay_code <= `PCT_PHASE_RST;
			ch6_volume_code <= `PCT_VOL_RST;
		end else if (reg_wr_en && page_hit) begin
			case (reg_addr)
			`PCT_ADDR_CH5_GAIN: begin
				// Low nibble is dropped on write
				ch5_gain_trim_code <=
					reg_wdata[`PCT_GAIN_MSB:`PCT_GAIN_LSB];
			end
			`PCT_ADDR_CH6_GAIN: begin
				ch6_gain_trim_code <=
					reg_wdata[`PCT_GAIN_MSB:`PCT_GAIN_LSB];
			end
			`PCT_ADDR_CH5_PHASE: begin
				ch5_phase_delay_code <= reg_wdata;
			end
			`PCT_ADDR_CH6_VOLUME: begin
				ch6_volume_code <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	always @* begin
		next_rdata = 8'h00;
		if (page_hit) begin
			case (reg_addr)
			`PCT_ADDR_CH5_GAIN: begin
				next_rdata = {ch5_gain_trim_code, 4'h0};
			end
			`PCT_ADDR_CH6_GAIN: begin
				next_rdata = {ch6_gain_trim_code, 4'h0};
			end
			`PCT_ADDR_CH5_PHASE: begin
				next_rdata = ch5_phase_delay_code;
			end
			`PCT_ADDR_CH6_VOLUME: begin
				next_rdata = ch6_volume_code;
			end
			default: begin
				next_rdata = 8'h00;
			end
			endcase
		end
	end

	// Read data holds until the next read
	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			reg_rdata <= next_rdata;
		end
	end

	// ************************************************************
	// Modulator clock enable
	// ************************************************************
	reg [7:0] div_cnt;

	always @(posedge core_clk) begin
		if (rst) begin
			div_cnt <= 8'h00;
			mod_tick <= 1'b0;
		end else if (div_cnt == MOD_DIV - 1) begin
			div_cnt <= 8'h00;
			mod_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			mod_tick <= 1'b0;
		end
	end

	// ************************************************************
	// Microphone pin synchronisers
	// ************************************************************
	reg [1:0] sync5;
	reg [1:0] sync6;

	always @(posedge core_clk) begin
		if (rst) begin
			sync5 <= 2'h0;
			sync6 <= 2'h0;
		end else begin
			sync5 <= {sync5[0], pdm_bit_ch5};
			sync6 <= {sync6[0], pdm_bit_ch6};
		end
	end

	// ************************************************************
	// Sample-boundary update of active settings
	// ************************************************************
	// Only the microphone path sees these; no analog use exists
	always @(posedge core_clk) begin
		if (rst) begin
			ch5_gain_tenth_db <= 5'sh00;
			ch6_gain_tenth_db <= 5'sh00;
			ch5_phase_active <= `PCT_PHASE_RST;
			ch6_volume_half_db <= 9'sh000;
			ch6_mute <= 1'b0;
		end else if (sample_strobe) begin
			ch5_gain_tenth_db <= $signed({1'b0, ch5_gain_trim_code}
				- `PCT_GAIN_ZERO_CODE);
			ch6_gain_tenth_db <= $signed({1'b0, ch6_gain_trim_code}
				- `PCT_GAIN_ZERO_CODE);
			ch5_phase_active <= ch5_phase_delay_code;
			// Units of 0.5 dB: 1 -> -200, 201 -> 0, 255 -> +54
			ch6_volume_half_db <= $signed({1'b0, ch6_volume_code}
				- `PCT_VOL_UNITY_CODE);
			ch6_mute <= (ch6_volume_code == `PCT_VOL_MUTE);
		end
	end

	// ************************************************************
	// Phase delay line
	// ************************************************************
	// Bits are written every modulator tick; the tap reads the entry
	// written phase-code ticks ago, before this tick overwrites it.
	reg [7:0] wr_ptr;
	reg tick_d;
	reg bit5_hold;
	reg bit6_hold;
	wire [0:0] tap_bit;
	wire [7:0] tap_addr;

	assign tap_addr = wr_ptr - ch5_phase_active;

	pct_delay_mem #(
		.WIDTH(1),
		.DEPTH(DEPTH),
		.AW(8)
	) u_delay (
		.core_clk(core_clk),
		.wr_en(mod_tick),
		.wr_addr(wr_ptr),
		.wr_data(sync5[1]),
		.rd_en(mod_tick),
		.rd_addr(tap_addr),
		.rd_data(tap_bit)
	);

	always @(posedge core_clk) begin
		if (rst) begin
			wr_ptr <= 8'h00;
			tick_d <= 1'b0;
			bit5_hold <= 1'b0;
			bit6_hold <= 1'b0;
		end else begin
			tick_d <= mod_tick;
			if (mod_tick) begin
				wr_ptr <= wr_ptr + 8'h01;
				bit5_hold <= sync5[1];
				bit6_hold <= sync6[1];
			end
		end
	end

	// Both channels leave with the same latency so code 0 keeps them
	// aligned; channel 6 has no phase trim here.
	always @(posedge core_clk) begin
		if (rst) begin
			pdm_delayed_ch5 <= 1'b0;
			pdm_delayed_ch6 <= 1'b0;
		end else if (tick_d) begin
			if (ch5_phase_active == 8'h00) begin
				pdm_delayed_ch5 <= bit5_hold;
			end else begin
				pdm_delayed_ch5 <= tap_bit[0];
			end
			pdm_delayed_ch6 <= bit6_hold;
		end
	end
endmodule

// ===== hw/pct_consts.vh
`ifndef PCT_CONSTS_VH
`define PCT_CONSTS_VH

// ****************************************************************
// Register map, page 0
// ****************************************************************
`define PCT_PAGE_MAIN 8'h00
`define PCT_ADDR_CH5_GAIN 8'h53
`define PCT_ADDR_CH5_PHASE 8'h54
`define PCT_ADDR_CH6_VOLUME 8'h57
`define PCT_ADDR_CH6_GAIN 8'h58

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PCT_GAIN_MSB 7
`define PCT_GAIN_LSB 4
`define PCT_GAIN_RST 4'h8
`define PCT_GAIN_REG_RST 8'h80
`define PCT_PHASE_RST 8'h00
`define PCT_VOL_RST 8'hC9
`define PCT_VOL_MUTE 8'h00
`define PCT_GAIN_ZERO_CODE 5'h08
`define PCT_VOL_UNITY_CODE 9'h0C9

// ****************************************************************
// Timing
// ****************************************************************
`define PCT_MOD_DIV 8
`define PCT_DELAY_DEPTH 256

`endif

// ===== hw/pct_delay_mem.v
// ****************************************************************
// Delay line storage: one write port, one registered read port
// ****************************************************************
module pct_delay_mem #(
	parameter WIDTH = 1,
	parameter DEPTH = 256,
	parameter AW = 8
) (
	input wire core_clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// Read sees the old contents when both ports hit one entry
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ===== bench/pct_trim_monitor.sv
// ****
// Register and trim output checks
// ****
module pct_trim_monitor #(
	parameter int MOD_DIV = 8
) (
	input wire core_clk,
	input wire rst,
	input wire [7:0] reg_page,
	input wire [7:0] reg_addr,
	input wire reg_rd_en,
	input wire [7:0] reg_rdata,
	input wire sample_strobe,
	input wire mod_tick,
	input wire pdm_delayed_ch5,
	input wire signed [4:0] ch5_gain_tenth_db,
	input wire signed [4:0] ch6_gain_tenth_db,
	input wire [7:0] ch5_phase_active,
	input wire signed [8:0] ch6_volume_half_db,
	input wire ch6_mute
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	low_bits_zero_a:
	assert property (reg_rd_en && (reg_addr == 8'h53 ||
		reg_addr == 8'h58) |=> reg_rdata[3:0] == 4'h0)
	else $error("gain trim low bits not zero");
	unmapped_page_a:
	assert property (reg_rd_en && reg_page != 8'h00 |=> reg_rdata == 8'h00)
	else $error("read from other page not zero");
	mute_tracks_vol_a:
	assert property (ch6_mute == (ch6_volume_half_db == -9'sd201))
	else $error("mute disagrees with volume");
	gain_range_a:
	assert property (ch5_gain_tenth_db <= 5'sd7 && ch6_gain_tenth_db <= 5'sd7)
	else $error("gain above top step");
	vol_hold_a:
	assert property (!$past(sample_strobe) |-> $stable(ch6_volume_half_db))
	else $error("volume moved off a sample boundary");
	trim_hold_a:
	assert property (!$past(sample_strobe) |-> $stable({ch5_gain_tenth_db,
		ch6_gain_tenth_db, ch5_phase_active}))
	else $error("trim moved off a sample boundary");
	tick_period_a:
	assert property (mod_tick |=> !mod_tick ##(MOD_DIV - 1) mod_tick)
	else $error("modulator tick period wrong");
	delay_on_tick_a:
	assert property ($changed(pdm_delayed_ch5) |-> $past(mod_tick, 2))
	else $error("delayed bit changed without a tick");
	reset_values_a:
	assert property ($past(rst) |-> ch6_volume_half_db == 9'sd0 &&
		ch5_gain_tenth_db == 5'sd0 && ch5_phase_active == 8'h00)
	else $error("decoded values wrong after reset");
endmodule
bind pct_trim_regs pct_trim_monitor #(.MOD_DIV(MOD_DIV)) mon_u (
	.core_clk(core_clk), .rst(rst), .reg_page(reg_page),
	.reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
	.sample_strobe(sample_strobe), .mod_tick(mod_tick),
	.pdm_delayed_ch5(pdm_delayed_ch5), .ch5_gain_tenth_db(ch5_gain_tenth_db),
	.ch6_gain_tenth_db(ch6_gain_tenth_db),
	.ch5_phase_active(ch5_phase_active),
	.ch6_volume_half_db(ch6_volume_half_db), .ch6_mute(ch6_mute));

// ===== bench/tb_top.sv
// ****
// Trim register bench
// ****
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst = 1, wr = 0, rd = 0, p5 = 0, p6 = 0, stb = 0;
	logic [7:0] page = 0, addr = 0, wd = 0, wv = 0;
	logic [31:0] seed = 32'h22517394;
	logic [1:0] th = 0;
	logic q5[$], q6[$];
	wire [7:0] rdata, ph;
	wire tick, d5, d6, mute;
	wire signed [4:0] g5, g6;
	wire signed [8:0] vol;
	int errors = 0, checks = 0, n, k, code = 0, skip = 4;
	int am[4] = '{8'h53, 8'h54, 8'h57, 8'h58};
	int mk[4] = '{8'hF0, 8'hFF, 8'hFF, 8'hF0};
	int rv[4] = '{8'h80, 8'h00, 8'hC9, 8'h80};
	int vt[6] = '{0, 1, 2, 201, 254, 255};
	int pt[3] = '{0, 3, 255};
	always #20 core_clk = ~core_clk;
	pct_trim_regs #(.MOD_DIV(2)) dut_u (.core_clk(core_clk), .rst(rst),
		.reg_page(page), .reg_addr(addr), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_wdata(wd), .reg_rdata(rdata), .pdm_bit_ch5(p5), .pdm_bit_ch6(p6),
		.sample_strobe(stb), .mod_tick(tick), .pdm_delayed_ch5(d5),
		.pdm_delayed_ch6(d6), .ch5_gain_tenth_db(g5), .ch6_gain_tenth_db(g6),
		.ch5_phase_active(ph), .ch6_volume_half_db(vol), .ch6_mute(mute));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(logic [8:0] got, logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(int c);
		repeat (c) @(negedge core_clk);
	endtask
	task wreg(logic [7:0] p, logic [7:0] a, logic [7:0] d);
		page = p;
		addr = a;
		wd = d;
		wr = 1;
		cyc(1);
		wr = 0;
		page = 0;
		cyc(1);
	endtask
	task rreg(logic [7:0] p, logic [7:0] a, logic [7:0] exp);
		page = p;
		addr = a;
		rd = 1;
		cyc(1);
		rd = 0;
		page = 0;
		chk(rdata, exp);
		cyc(1);
	endtask
	task pulse;
		stb = 1;
		cyc(1);
		stb = 0;
		cyc(1);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Pin bits kept in tick order; an output shows the bit driven two
	// ticks before the latest one (synchroniser plus capture pipeline)
	always @(negedge core_clk) begin
		th <= {th[0], tick};
		if (rst) begin
			q5.delete();
			q6.delete();
		end else begin
			if (tick) begin
				seed = lfsr(seed);
				p5 <= seed[0];
				p6 <= seed[1];
				q5.push_back(seed[0]);
				q6.push_back(seed[1]);
			end
			if (th[1] && skip > 0) begin
				skip--;
			end else if (th[1] && q5.size() > code + 2) begin
				chk(d6, q6[q6.size() - 3]);
				chk(d5, q5[q5.size() - 3 - code]);
			end
		end
	end
	initial begin
		cyc(20000);
		errors++;
		complete_run;
	end
	initial begin
		cyc(6);
		rst = 0;
		wreg(1, 8'h57, 8'h12);
		wreg(0, 8'h55, 8'h34);
		for (k = 0; k < 4; k++)
			rreg(0, am[k], rv[k]);
		rreg(0, 8'h55, 0);
		rreg(1, 8'h57, 0);
		$display("test reset and map done");
		for (n = 0; n < 20; n++) begin
			seed = lfsr(seed);
			wv = seed[7:0];
			wreg(0, am[n % 4], wv);
			rreg(0, am[n % 4], wv & mk[n % 4]);
		end
		wreg(0, 8'h54, 0);
		$display("test readback done");
		for (n = 0; n < 16; n++) begin
			wreg(0, 8'h53, n << 4 | 4'hF);
			wreg(0, 8'h58, (15 - n) << 4);
			pulse;
			chk(9'(g5), 9'(n - 8));
			chk(9'(g6), 9'(7 - n));
		end
		$display("test gain done");
		for (n = 0; n < 6; n++) begin
			wreg(0, 8'h57, vt[n]);
			pulse;
			chk(9'(vol), 9'(vt[n] - 201));
			chk(mute, vt[n] == 0);
		end
		$display("test volume done");
		for (n = 0; n < 3; n++) begin
			wreg(0, 8'h54, pt[n]);
			skip = 4;
			code = pt[n];
			pulse;
			chk(ph, pt[n]);
			cyc(2 * pt[n] + 60);
		end
		$display("test phase done");
		// Reset over written values must bring every register back
		rst = 1;
		code = 0;
		cyc(4);
		rst = 0;
		for (k = 0; k < 4; k++)
			rreg(0, am[k], rv[k]);
		chk(ph, 0);
		chk(9'(vol), 0);
		chk(mute, 0);
		cyc(20);
		$display("test mid-run reset done");
		complete_run;
	end
endmodule
